// File: icf_consts.vh
// Constants for the input capture FIFO unit: offsets, fields, resets.
// Assumes a single 250 MHz clock and a plain strobe register port.
`ifndef ICF_CONSTS_VH
`define ICF_CONSTS_VH
`define ICF_ADDR_W 3
`define ICF_A_CON1_ODD 3'h0
`define ICF_A_CON2_ODD 3'h1
`define ICF_A_BUF_LOW 3'h2
`define ICF_A_CON1_EVEN 3'h4
`define ICF_A_CON2_EVEN 3'h5
`define ICF_A_BUF_HIGH 3'h6
`define ICF_CON1_RST 16'h0000
`define ICF_CON2_RST 16'h0000
`define ICF_B_MODE_LO 0
`define ICF_B_MODE_HI 2
`define ICF_B_BNE 3
`define ICF_B_RATE_LO 5
`define ICF_B_RATE_HI 6
`define ICF_B_TSEL_LO 10
`define ICF_B_TSEL_HI 12
`define ICF_B_SSEL_LO 0
`define ICF_B_SSEL_HI 4
`define ICF_B_TSTAT 6
`define ICF_B_TRIG 7
`define ICF_B_CASC 8
`define ICF_M_OFF 3'h0
`define ICF_M_EDGE 3'h1
`define ICF_M_FALL 3'h2
`define ICF_M_RISE 3'h3
`define ICF_M_RISE4 3'h4
`define ICF_M_RISE16 3'h5
`define ICF_PRE4_CNT 5'h03
`define ICF_PRE16_CNT 5'h0f
`endif

// File: icf_capture.v
// Input capture pair (odd low half, even high half) with capture FIFOs.
// Assumes time bases and source enables arrive as ref_clk-domain levels,
// capture pins are asynchronous and are synchronised here.
//
// Design decisions made here: the address-and-strobe port and the address map.
`include "icf_consts.vh"
module icf_capture #(
   parameter DEPTH = 4,
   parameter AW = 2
)(
   // Clock and reset
   input wire ref_clk,
   input wire reset,
   // Register port
   input wire [`ICF_ADDR_W-1:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // Capture pins
   input wire capture_input_pin_odd,
   input wire capture_input_pin_even,
   // Time base and source enables
   input wire [7:0] time_base_en,
   input wire [31:1] source_en,
   // Interrupt requests
   output reg irq_odd_r,
   output reg irq_even_r
);
   reg [15:0] con1_r [0:1];
   reg [15:0] con2_r [0:1];
   reg [15:0] cnt_r [0:1];
   reg [15:0] fifo_r [0:1][0:DEPTH-1];
   reg [AW-1:0] wp_r [0:1];
   reg [AW-1:0] rp_r [0:1];
   reg [AW:0] lvl_r [0:1];
   reg [4:0] pre_r [0:1];
   reg [1:0] ev_r [0:1];
   reg [1:0] s1_r, s2_r, s3_r;
   reg armed_r [0:1];
   reg casc_w;
   wire [1:0] irq_w;
   integer k;

   localparam [AW:0] FULL_LVL = DEPTH;

   // Source code 0 means none selected
   function src_on;
      input [4:0] sel;
      begin
         src_on = (sel == 5'h00) ? 1'b0 : source_en[sel];
      end
   endfunction

   // not-empty flag replaces stored bit 3
   function [15:0] stat_word;
      input [15:0] con;
      input [AW:0] lvl;
      begin
         stat_word = {con[15:4], (lvl != {(AW+1){1'b0}}), con[2:0]};
      end
   endfunction

   // Pin synchronisers; s2 is the first stage anything reads
   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         s1_r <= 2'b00;
         s2_r <= 2'b00;
         s3_r <= 2'b00;
      end
      else
      begin
         s1_r <= {capture_input_pin_even, capture_input_pin_odd};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   always @*
   begin
      casc_w = con2_r[0][`ICF_B_CASC] & con2_r[1][`ICF_B_CASC];
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : mod
         wire [15:0] c1 = (casc_w) ? con1_r[0] : con1_r[g];
         wire [15:0] c2 = (casc_w) ? con2_r[0] : con2_r[g];
         wire [2:0] mode = c1[`ICF_B_MODE_HI:`ICF_B_MODE_LO];
         wire [1:0] rate = c1[`ICF_B_RATE_HI:`ICF_B_RATE_LO];
         wire [4:0] ssel = c2[`ICF_B_SSEL_HI:`ICF_B_SSEL_LO];
         wire trig = c2[`ICF_B_TRIG];
         wire tb_on = time_base_en[c1[`ICF_B_TSEL_HI:`ICF_B_TSEL_LO]];
         wire go = tb_on & ((trig) ? c2[`ICF_B_TSTAT] : src_on(ssel));
         wire pin = (casc_w) ? s3_r[0] : s3_r[g];
         wire pin_d = (casc_w) ? s2_r[0] : s2_r[g];
         wire rise = pin_d & ~pin;
         wire fall = ~pin_d & pin;
         reg hit;
         always @*
         begin
            case (mode)
               `ICF_M_EDGE: hit = rise | fall;
               `ICF_M_FALL: hit = fall;
               `ICF_M_RISE: hit = rise;
               `ICF_M_RISE4: hit = rise & (pre_r[g] == `ICF_PRE4_CNT);
               `ICF_M_RISE16: hit = rise & (pre_r[g] == `ICF_PRE16_CNT);
               default: hit = 1'b0;
            endcase
         end
         wire arm = (casc_w) ? armed_r[0] : armed_r[g];
         wire cap = hit & arm & go;
         wire tick = (casc_w && g == 1) ? (armed_r[0] & go & (cnt_r[0] == 16'hffff))
                                         : (armed_r[g] & go);
         wire rd = reg_rd & (reg_addr == ((g == 0) ? `ICF_A_BUF_LOW : `ICF_A_BUF_HIGH));
         wire pop = rd & (lvl_r[g] != {(AW+1){1'b0}});
         wire push = cap & (lvl_r[g] != FULL_LVL);
         always @(posedge ref_clk)
         begin
            if (reset)
            begin
               cnt_r[g] <= 16'h0000;
               pre_r[g] <= 5'h00;
               armed_r[g] <= 1'b0;
            end
            else
            begin
               if (reg_wr && reg_addr == ((g == 0) ? `ICF_A_CON1_ODD : `ICF_A_CON1_EVEN))
                  armed_r[g] <= (reg_wdata[`ICF_B_MODE_HI:`ICF_B_MODE_LO] != `ICF_M_OFF);
               // held in reset until time base and source on
               if (!go)
               begin
                  cnt_r[g] <= 16'h0000;
                  pre_r[g] <= 5'h00;
               end
               else
               begin
                  if (tick)
                     cnt_r[g] <= cnt_r[g] + 16'h0001;
                  if (rise && (mode == `ICF_M_RISE4 || mode == `ICF_M_RISE16))
                     pre_r[g] <= (hit) ? 5'h00 : pre_r[g] + 5'h01;
               end
            end
         end

         // FIFO write side; a full FIFO keeps its entries
         // Pointer wraps; the level tells full from empty
         always @(posedge ref_clk)
         begin
            if (reset)
            begin
               wp_r[g] <= {AW{1'b0}};
            end
            else if (push)
            begin
               fifo_r[g][wp_r[g]] <= cnt_r[g];
               wp_r[g] <= wp_r[g] + {{(AW-1){1'b0}}, 1'b1};
            end
         end

         // Read of an empty FIFO leaves the pointer alone
         always @(posedge ref_clk)
         begin
            if (reset)
            begin
               rp_r[g] <= {AW{1'b0}};
            end
            else if (pop)
            begin
               rp_r[g] <= rp_r[g] + {{(AW-1){1'b0}}, 1'b1};
            end
         end

         // level falls to zero on the last read
         always @(posedge ref_clk)
         begin
            if (reset)
            begin
               lvl_r[g] <= {(AW+1){1'b0}};
            end
            else if (push && !pop)
            begin
               lvl_r[g] <= lvl_r[g] + {{AW{1'b0}}, 1'b1};
            end
            else if (pop && !push)
            begin
               lvl_r[g] <= lvl_r[g] - {{AW{1'b0}}, 1'b1};
            end
         end

         // event counter restarts on each interrupt
         always @(posedge ref_clk)
         begin
            if (reset)
            begin
               ev_r[g] <= 2'b00;
            end
            else if (cap)
            begin
               if (ev_r[g] == rate)
                  ev_r[g] <= 2'b00;
               else
                  ev_r[g] <= ev_r[g] + 2'b01;
            end
         end

         // every (rate + 1)th capture interrupts
         reg irq_hit;
         always @*
         begin
            irq_hit = 1'b0;
            if (cap && ev_r[g] == rate)
               irq_hit = 1'b1;
         end
         assign irq_w[g] = irq_hit;
      end
   endgenerate

   // Interrupt pulses; a cascaded pair interrupts on the odd line only
   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         irq_odd_r <= 1'b0;
         irq_even_r <= 1'b0;
      end
      else
      begin
         irq_odd_r <= irq_w[0];
         irq_even_r <= irq_w[1] & ~casc_w;
      end
   end

   // Control register writes and reads
   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         for (k = 0; k < 2; k = k + 1)
         begin
            con1_r[k] <= `ICF_CON1_RST;
            con2_r[k] <= `ICF_CON2_RST;
         end
      end
      else
      begin
         if (reg_wr)
         begin
            case (reg_addr)
               `ICF_A_CON1_ODD: con1_r[0] <= reg_wdata;
               `ICF_A_CON2_ODD: con2_r[0] <= reg_wdata;
               `ICF_A_CON1_EVEN: con1_r[1] <= reg_wdata;
               `ICF_A_CON2_EVEN: con2_r[1] <= reg_wdata;
               default: ;
            endcase
         end
         // trigger status set by source, cleared by software
         for (k = 0; k < 2; k = k + 1)
            if (con2_r[k][`ICF_B_TRIG] && src_on(con2_r[k][`ICF_B_SSEL_HI:`ICF_B_SSEL_LO]))
               con2_r[k][`ICF_B_TSTAT] <= 1'b1;
      end
   end

   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         reg_rdata <= 16'h0000;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            `ICF_A_CON1_ODD: reg_rdata <= stat_word(con1_r[0], lvl_r[0]);
            `ICF_A_CON2_ODD: reg_rdata <= con2_r[0];
            `ICF_A_BUF_LOW: reg_rdata <= fifo_r[0][rp_r[0]];
            `ICF_A_CON1_EVEN: reg_rdata <= stat_word(con1_r[1], lvl_r[1]);
            `ICF_A_CON2_EVEN: reg_rdata <= con2_r[1];
            `ICF_A_BUF_HIGH: reg_rdata <= fifo_r[1][rp_r[1]];
            default: reg_rdata <= 16'h0000;
         endcase
      end
      else
      begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule

// File: icf_capture_checker.sv
// Checker for the capture pair: register port answers and interrupt pulses.
// Sees only the top ports; one clock domain, synchronous reset.
module icf_capture_checker (
   input wire ref_clk,
   input wire reset,
   input wire [2:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire capture_input_pin_odd,
   input wire [7:0] time_base_en,
   input wire irq_odd_r,
   input wire irq_even_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_wr_rd(a);
      reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
   endsequence
   sequence s_pin_quiet;
      $stable(capture_input_pin_odd) [*8];
   endsequence
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_rst_quiet;
      $fell(reset) |-> reg_rdata == 16'h0000 && !irq_odd_r && !irq_even_r;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
   property p_pin_quiet;
      s_pin_quiet |=> !irq_odd_r;
   endproperty
   a_pin_quiet: assert property (p_pin_quiet) else $error("interrupt without edge");
   property p_no_base;
      (time_base_en == 8'h00) [*8] |=> !irq_odd_r && !irq_even_r;
   endproperty
   a_no_base: assert property (p_no_base) else $error("interrupt with no time base");
   property p_irq_pulse;
      irq_odd_r |=> !irq_odd_r;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a cycle");
   property p_unmapped;
      reg_rd && reg_addr[1:0] == 2'h3 |=> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_con2_back;
      s_wr_rd(3'h1) |=> reg_rdata[8:7] == $past(reg_wdata[8:7], 2)
         && reg_rdata[4:0] == $past(reg_wdata[4:0], 2);
   endproperty
   a_con2_back: assert property (p_con2_back) else $error("control two readback");
   property p_con1_back;
      s_wr_rd(3'h0) |=> reg_rdata[12:10] == $past(reg_wdata[12:10], 2)
         && reg_rdata[6:5] == $past(reg_wdata[6:5], 2) && reg_rdata[2:0] == $past(reg_wdata[2:0], 2);
   endproperty
   a_con1_back: assert property (p_con1_back) else $error("control one readback");
endmodule
bind icf_capture icf_capture_checker i_chk (.ref_clk(ref_clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .capture_input_pin_odd(capture_input_pin_odd),
   .time_base_en(time_base_en), .irq_odd_r(irq_odd_r), .irq_even_r(irq_even_r));

// File: icf_pin_model.sv
// Edge source standing at the capture pins.
// Idles low; pulses are slow enough for the pin synchroniser.
module icf_pin_model (
   input wire ref_clk,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin = 1'b0;
   task automatic edges(input int n);
      repeat (n)
      begin
         repeat (4) @(posedge ref_clk);
         pin <= 1'b1;
         repeat (4) @(posedge ref_clk);
         pin <= 1'b0;
      end
   endtask
endmodule

// File: testbench.sv
// Self-checking bench for the capture pair: register port, pins, enables.
// Assumes the pin model drives both capture pins with one wave.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, rd_q = 0, pin, irq_odd_r, irq_even_r;
   logic [2:0] reg_addr = 0;
   logic [15:0] reg_wdata = 0, reg_rdata, last;
   logic [7:0] time_base_en = 0;
   logic [31:1] source_en = 0;
   logic [31:0] e, exp_q[$];
   logic [2:0] md[5] = '{3'h3, 3'h4, 3'h5, 3'h1, 3'h3};
   int eg[5] = '{2, 8, 16, 2, 6};
   int ex[5] = '{2, 2, 1, 4, 4};
   int mismatches = 0, check_count = 0, irq_n = 0, ie_n = 0;
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      if (irq_odd_r === 1'b1)
         irq_n++;
      if (!reset && irq_even_r !== 1'b0)
         ie_n++;
      if (rd_q)
      begin
         e = exp_q.pop_front();
         chk(reg_rdata & e[31:16], e[15:0]);
      end
      rd_q <= reg_rd;
   end
   icf_pin_model i_pin (.ref_clk(ref_clk), .pin(pin));
   icf_capture #(.DEPTH(4), .AW(2)) i_dut (.ref_clk(ref_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .capture_input_pin_odd(pin), .capture_input_pin_even(pin),
      .time_base_en(time_base_en), .source_en(source_en), .irq_odd_r(irq_odd_r),
      .irq_even_r(irq_even_r));
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      check_count++;
      if (seen !== want)
      begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] m, input logic [15:0] w);
      exp_q.push_back({m, w});
      reg_wr <= 1'b0;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      last = reg_rdata;
   endtask
   task automatic burst(input int n);
      irq_n = 0;
      reg_wr <= 1'b0;
      i_pin.edges(n);
      repeat (12) @(posedge ref_clk);
   endtask
   task automatic drain(input int want, input bit c);
      int k;
      k = 0;
      rd(3'h0, 16'h0008, want > 0 ? 16'h0008 : 16'h0000);
      while (last[3] === 1'b1 && k < 40)
      begin
         rd(3'h2, 16'h0000, 16'h0000);
         if (c)
            rd(3'h6, 16'hffff, 16'h0000);
         k++;
         rd(3'h0, 16'h0000, 16'h0000);
      end
      chk(k, want);
      rd(3'h0, 16'h0008, 16'h0000);
      if (c)
         rd(3'h4, 16'h0008, 16'h0000);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      eg[0] = $urandom(32'h2fd6c25c);
      eg[0] = 1 + $urandom % 4;
      ex[0] = eg[0];
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      rd(3'h0, 16'hffff, 16'h0000);
      rd(3'h5, 16'hffff, 16'h0000);
      rd(3'h3, 16'hffff, 16'h0000);
      time_base_en <= 8'h01;
      source_en <= 31'h1;
      for (int i = 0; i < 5; i++)
      begin
         wr(3'h1, 16'h0001);
         rd(3'h1, 16'h01df, 16'h0001);
         wr(3'h0, 16'h0000);
         wr(3'h0, {13'h0000, md[i]});
         rd(3'h0, 16'h0007, {13'h0000, md[i]});
         burst(eg[i]);
         if (i < 4)
            chk(irq_n, ex[i]);
         drain(ex[i], 1'b0);
      end
      wr(3'h0, 16'h0023);
      burst(4);
      chk(irq_n, 2);
      drain(4, 1'b0);
      wr(3'h1, 16'h0082);
      wr(3'h0, 16'h0000);
      wr(3'h0, 16'h0003);
      burst(2);
      drain(0, 1'b0);
      source_en <= 31'h2;
      @(posedge ref_clk);
      source_en <= 31'h0;
      rd(3'h1, 16'h0040, 16'h0040);
      burst(2);
      drain(2, 1'b0);
      wr(3'h1, 16'h0082);
      rd(3'h1, 16'h0040, 16'h0000);
      wr(3'h5, 16'h0101);
      wr(3'h1, 16'h0101);
      wr(3'h4, 16'h0000);
      wr(3'h0, 16'h0000);
      wr(3'h0, 16'h0003);
      burst(2);
      drain(0, 1'b1);
      source_en <= 31'h1;
      burst(3);
      drain(3, 1'b1);
      chk(ie_n, 0);
      test_done();
   end
endmodule
